// >>> verilog/fesq_pkg.sv
// constants and types for the flash erase/program sequencer host controller
// assumes a 100 MHz system clock and a byte-wide flash on asynchronous strobes
package fesq_pkg;
   localparam int CLK_MHZ   = 100;
   // bus cycle timing, in ns as figures, then rounded up to cycles
   localparam int T_WE_NS   = 50;
   localparam int T_RD_NS   = 120;
   localparam logic [3:0] WE_CYC = 4'((T_WE_NS * CLK_MHZ + 999) / 1000);
   localparam logic [3:0] RD_CYC = 4'((T_RD_NS * CLK_MHZ + 999) / 1000);
   // sector load window and suspend latency, in us, then in cycles
   localparam int T_LOAD_US = 80;
   localparam int T_SUSP_US = 100;
   localparam int LOAD_CYC_DEF = T_LOAD_US * CLK_MHZ;
   localparam int SUSP_CYC_DEF = T_SUSP_US * CLK_MHZ;

   // unlock pattern and command codes
   localparam logic [19:0] UNLOCK1_ADDR = 20'h00555;
   localparam logic [19:0] UNLOCK2_ADDR = 20'h002aa;
   localparam logic [7:0]  UNLOCK1_DATA = 8'haa;
   localparam logic [7:0]  UNLOCK2_DATA = 8'h55;
   localparam logic [7:0]  CMD_SETUP    = 8'h80;
   localparam logic [7:0]  CMD_SECTOR   = 8'h30;
   localparam logic [7:0]  CMD_SUSPEND  = 8'hb0;
   localparam logic [7:0]  CMD_RESUME   = 8'h30;
   localparam logic [7:0]  CMD_PROGRAM  = 8'ha0;
   localparam logic [7:0]  CMD_RESET    = 8'hf0;

   // status byte bit positions
   localparam int DATA_POLL_BIT    = 7;
   localparam int TOGGLE_BIT_ONE   = 6;
   localparam int TIMEOUT_FLAG_BIT = 5;
   localparam int ERASE_WINDOW_BIT = 3;
   localparam int SECTOR_TOGGLE_BIT = 2;

   // sequence lengths in bus writes
   localparam logic [2:0] LEN_PROGRAM = 3'h4;
   localparam logic [2:0] LEN_ERASE   = 3'h6;
   localparam logic [2:0] LEN_SINGLE  = 3'h1;

   // register offsets
   localparam logic [11:0] REG_CTRL   = 12'h000;
   localparam logic [11:0] REG_ADDR   = 12'h004;
   localparam logic [11:0] REG_WDATA  = 12'h008;
   localparam logic [11:0] REG_STATUS = 12'h00c;
   localparam logic [11:0] REG_RDATA  = 12'h010;

   // status register field positions
   localparam int ST_BUSY    = 0;
   localparam int ST_DONE    = 1;
   localparam int ST_FAIL    = 2;
   localparam int ST_REFUSED = 3;
   localparam int ST_WINDOW  = 4;
   localparam int ST_SUSP    = 5;
   localparam int ST_ERASING = 6;
   localparam int ST_BYTE_LO = 8;

   typedef enum logic [2:0] {
      OP_READ    = 3'b000,
      OP_PROGRAM = 3'b001,
      OP_ERASE   = 3'b010,
      OP_ADD     = 3'b011,
      OP_SUSPEND = 3'b100,
      OP_RESUME  = 3'b101,
      OP_RESET   = 3'b110,
      OP_POLL    = 3'b111
   } fesq_op_t;
endpackage

// >>> verilog/fesq_cycle.sv
// one flash bus cycle, write or read, with strobe timing from fesq_pkg
// assumes flash data input is synchronous to clk; start is held until done
`timescale 1ns/100ps
module fesq_cycle
   import fesq_pkg::*;
(
   input  wire logic        clk,
   input  wire logic        rst_n,
   input  wire logic        en,
   input  wire logic        req,
   input  wire logic        is_write,
   input  wire logic [19:0] addr,
   input  wire logic [7:0]  wdata,
   output logic             done,
   output logic [7:0]       rdata,
   output logic             flash_ce_n,
   output logic             flash_we_n,
   output logic             flash_oe_n,
   output logic [19:0]      flash_addr,
   output logic [7:0]       flash_dq_o,
   output logic             flash_dq_oe_n,
   input  wire logic [7:0]  flash_dq_i
);
   typedef enum logic [1:0] {
      CY_IDLE  = 2'b00,
      CY_SETUP = 2'b01,
      CY_PULSE = 2'b10,
      CY_HOLD  = 2'b11
   } fesq_cy_t;

   fesq_cy_t   st_q;
   logic [3:0] cnt_q;
   logic       wr_q;

   assign done = (st_q == CY_HOLD);

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         st_q          <= CY_IDLE;
         cnt_q         <= 4'h0;
         wr_q          <= 1'b0;
         flash_ce_n    <= 1'b1;
         flash_we_n    <= 1'b1;
         flash_oe_n    <= 1'b1;
         flash_addr    <= 20'h00000;
         flash_dq_o    <= 8'h00;
         flash_dq_oe_n <= 1'b1;
         rdata         <= 8'h00;
      end else if (en) begin
         case (st_q)
            CY_IDLE: begin
               if (req) begin
                  // address settles before the strobe falls
                  st_q          <= CY_SETUP;
                  wr_q          <= is_write;
                  flash_addr    <= addr;
                  flash_dq_o    <= wdata;
                  flash_dq_oe_n <= !is_write;
                  flash_ce_n    <= 1'b0;
               end
            end
            CY_SETUP: begin
               // falling edge of strobe: device latches address
               st_q       <= CY_PULSE;
               cnt_q      <= wr_q ? WE_CYC : RD_CYC;
               flash_we_n <= !wr_q; // RULE2
               flash_oe_n <= wr_q;
            end
            CY_PULSE: begin
               if (cnt_q <= 4'h1) begin
                  // rising edge of strobe: device latches data and starts
                  st_q       <= CY_HOLD;
                  flash_we_n <= 1'b1;
                  flash_oe_n <= 1'b1;
                  flash_ce_n <= 1'b1;
                  if (!wr_q) begin
                     rdata <= flash_dq_i;
                  end
               end else begin
                  cnt_q <= cnt_q - 4'h1;
               end
            end
            CY_HOLD: begin
               st_q          <= CY_IDLE;
               flash_dq_oe_n <= 1'b1;
            end
            default: st_q <= CY_IDLE;
         endcase
      end
   end
endmodule // fesq_cycle

// >>> verilog/fesq_host.sv
// host controller: apb registers order command sequences to a byte-wide flash
// assumes apb in the clk domain and flash strobes driven from fesq_cycle
// What this block does
// RULE1 - erase needs six writes ending 30H
// RULE2 - sector address held across strobe
// RULE3 - add sectors within load window
// RULE4 - other writes abort load window
// RULE5 - erase self-timed, no host control
// RULE6 - erase done: poll 1, toggle steady
// RULE7 - suspend only during sector erase
// RULE8 - suspend completes within time limit
// RULE9 - suspended: read, resume, program only; reset also accepted while suspended
// RULE10 - resume only after accepted suspend
// RULE11 - program: two unlocks, A0H, data
// RULE12 - program strobe rise starts programming
// RULE13 - program done: toggle steady, bits match
// RULE14 - timeout flag marks failure
// RULE15 - program poll bit complemented until done
// RULE16 - erase poll bit 0 until done
// RULE17 - polling valid in load window
// RULE18 - suspended sector shows fixed status
// RULE19 - suspend program toggles bit
// RULE20 - other sectors read array data
// RULE21 - window bit high once erasing
// RULE22 - reset code aborts failed operation
// RULE23 - fixed unlock address/data pairs
// RULE24 - top four address bits select sector
// RULE25 - reads during algorithm give status
//
// The implementer's own choices: the APB interface to the registers and the address map.
`timescale 1ns/100ps
module fesq_host
   import fesq_pkg::*;
#(
   parameter int LOAD_CYC = LOAD_CYC_DEF,
   parameter int SUSP_CYC = SUSP_CYC_DEF
)
(
   input  wire logic        clk,
   input  wire logic        resetn,
   input  wire logic        en,
   input  wire logic        psel,
   input  wire logic        penable,
   input  wire logic        pwrite,
   input  wire logic [11:0] paddr,
   input  wire logic [31:0] pwdata,
   output logic [31:0]      prdata,
   output logic             pready,
   output logic             pslverr,
   output logic             flash_ce_n,
   output logic             flash_we_n,
   output logic             flash_oe_n,
   output logic [19:0]      flash_addr,
   output logic [7:0]       flash_dq_o,
   output logic             flash_dq_oe_n,
   input  wire logic [7:0]  flash_dq_i
);
   typedef enum logic [2:0] {
      ST_IDLE   = 3'b000,
      ST_WR     = 3'b001,
      ST_RD_A   = 3'b010,
      ST_RD_B   = 3'b011,
      ST_RD_ONE = 3'b100
   } fesq_st_t;
   function automatic logic [2:0] seq_len(input fesq_op_t op);
      case (op)
         OP_PROGRAM: seq_len = LEN_PROGRAM;
         OP_ERASE:   seq_len = LEN_ERASE;
         default:    seq_len = LEN_SINGLE;
      endcase
   endfunction
   function automatic logic [27:0] seq_word(input fesq_op_t op, input logic [2:0] step,
                                            input logic [19:0] a, input logic [7:0] d);
      logic [7:0] code;
      case (op)
         OP_ADD:     code = CMD_SECTOR;
         OP_SUSPEND: code = CMD_SUSPEND;
         OP_RESUME:  code = CMD_RESUME;
         default:    code = CMD_RESET;
      endcase
      if (op == OP_PROGRAM || op == OP_ERASE) begin
         case (step)
            3'h0:    seq_word = {UNLOCK1_ADDR, UNLOCK1_DATA}; // RULE23
            3'h1:    seq_word = {UNLOCK2_ADDR, UNLOCK2_DATA}; // RULE23
            3'h2:    seq_word = {UNLOCK1_ADDR, (op == OP_PROGRAM) ? CMD_PROGRAM : CMD_SETUP}; // RULE1 RULE11
            3'h3:    seq_word = (op == OP_PROGRAM) ? {a, d} : {UNLOCK1_ADDR, UNLOCK1_DATA}; // RULE11 RULE12
            3'h4:    seq_word = {UNLOCK2_ADDR, UNLOCK2_DATA};
            default: seq_word = {a, CMD_SECTOR}; // RULE1 RULE24
         endcase
      end else begin
         seq_word = {a, code};
      end
   endfunction
   logic [1:0]  rst_sync_q;
   fesq_st_t    st_q;
   fesq_op_t    op_q, new_op;
   logic [2:0]  step_q;
   logic [19:0] addr_q;
   logic [7:0]  wdata_q, rd_a_q, rdata_q, stat_byte_q, eng_rdata;
   logic [15:0] win_cnt_q, poll_cnt_q;
   logic [27:0] word;
   logic        rst_n, tmo_seen_q, erasing_q, suspended_q, done_q, fail_q, refused_q;
   logic        eng_req, eng_done, apb_wr, wr_ctrl, accept, legal, window_open, wr_last;
   logic        eval, steady, pass_cond, fin_ok, fin_bad, mapped;
   always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         rst_sync_q <= 2'b00;
      end else begin
         rst_sync_q <= {rst_sync_q[0], 1'b1};
      end
   end
   assign rst_n = rst_sync_q[1];
   assign new_op      = fesq_op_t'(pwdata[2:0]);
   assign apb_wr      = psel && penable && pwrite;
   assign wr_ctrl     = apb_wr && (paddr == REG_CTRL);
   assign window_open = erasing_q && !suspended_q && (win_cnt_q < 16'(LOAD_CYC)); // RULE3 RULE17
   always_comb begin
      case (new_op)
         OP_READ:    legal = 1'b1; // RULE20 RULE25
         OP_PROGRAM: legal = !erasing_q || suspended_q; // RULE9 RULE4
         OP_ERASE:   legal = !erasing_q; // RULE21
         OP_ADD:     legal = window_open; // RULE3
         OP_SUSPEND: legal = erasing_q && !suspended_q; // RULE7
         OP_RESUME:  legal = suspended_q; // RULE10
         OP_POLL:    legal = erasing_q && !suspended_q;
         default:    legal = 1'b1;
      endcase
   end
   assign accept = wr_ctrl && (st_q == ST_IDLE) && legal;
   assign eng_req = (st_q != ST_IDLE);
   assign word    = seq_word(op_q, step_q, addr_q, wdata_q);
   assign wr_last = (st_q == ST_WR) && eng_done && (step_q == seq_len(op_q) - 3'h1);
   assign eval   = (st_q == ST_RD_B) && eng_done;
   assign steady = (rd_a_q[TOGGLE_BIT_ONE] == eng_rdata[TOGGLE_BIT_ONE]); // RULE6 RULE13 RULE19
   always_comb begin
      case (op_q)
         OP_PROGRAM: pass_cond = (eng_rdata[7:6] == wdata_q[7:6]); // RULE13 RULE15
         OP_POLL:    pass_cond = eng_rdata[DATA_POLL_BIT]; // RULE6 RULE16
         default:    pass_cond = 1'b1; // RULE18
      endcase
   end
   assign fin_ok  = eval && steady && pass_cond;
   assign fin_bad = eval && ((steady && !pass_cond)
                    || (!steady && eng_rdata[TIMEOUT_FLAG_BIT] && tmo_seen_q) // RULE14
                    || (op_q == OP_SUSPEND && poll_cnt_q >= 16'(SUSP_CYC))); // RULE8
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         st_q       <= ST_IDLE;
         op_q       <= OP_READ;
         step_q     <= 3'h0;
         rd_a_q     <= 8'h00;
         tmo_seen_q <= 1'b0;
      end else if (en) begin
         case (st_q)
            ST_IDLE: begin
               if (accept) begin
                  op_q       <= new_op;
                  step_q     <= 3'h0;
                  tmo_seen_q <= 1'b0;
                  st_q       <= (new_op == OP_READ) ? ST_RD_ONE : (new_op == OP_POLL) ? ST_RD_A : ST_WR;
               end
            end
            ST_WR: begin
               if (wr_last) begin
                  st_q <= (op_q == OP_PROGRAM || op_q == OP_SUSPEND) ? ST_RD_A : ST_IDLE; // RULE5
               end else if (eng_done) begin
                  step_q <= step_q + 3'h1;
               end
            end
            ST_RD_A: begin
               if (eng_done) begin
                  rd_a_q <= eng_rdata;
                  st_q   <= ST_RD_B;
               end
            end
            ST_RD_B: begin
               if (fin_bad) begin
                  op_q   <= OP_RESET; // RULE22
                  step_q <= 3'h0;
                  st_q   <= ST_WR;
               end else if (fin_ok) begin
                  st_q <= ST_IDLE;
               end else if (eval) begin
                  tmo_seen_q <= tmo_seen_q || eng_rdata[TIMEOUT_FLAG_BIT]; // RULE14
                  st_q       <= ST_RD_A;
               end
            end
            ST_RD_ONE: begin
               if (eng_done) begin
                  st_q <= ST_IDLE;
               end
            end
            default: st_q <= ST_IDLE;
         endcase
      end
   end
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         erasing_q   <= 1'b0;
         suspended_q <= 1'b0;
         win_cnt_q   <= 16'h0000;
         poll_cnt_q  <= 16'h0000;
      end else if (en) begin
         if (accept && new_op == OP_ERASE) begin
            erasing_q <= 1'b1;
         end else if ((fin_ok && op_q == OP_POLL) || (wr_last && op_q == OP_RESET)) begin
            erasing_q <= 1'b0;
         end
         if (fin_ok && op_q == OP_SUSPEND) begin
            suspended_q <= 1'b1; // RULE8
         end else if (wr_last && (op_q == OP_RESUME || op_q == OP_RESET)) begin
            suspended_q <= 1'b0; // RULE10
         end
         if (wr_last && (op_q == OP_ERASE || op_q == OP_ADD)) begin
            win_cnt_q <= 16'h0000; // RULE3
         end else if (accept && new_op == OP_SUSPEND) begin
            win_cnt_q <= 16'(LOAD_CYC); // RULE8
         end else if (erasing_q && win_cnt_q < 16'(LOAD_CYC)) begin
            win_cnt_q <= win_cnt_q + 16'h0001;
         end
         if (accept) begin
            poll_cnt_q <= 16'h0000;
         end else if (st_q == ST_RD_A || st_q == ST_RD_B) begin
            poll_cnt_q <= poll_cnt_q + 16'h0001;
         end
      end
   end
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         done_q    <= 1'b0;
         fail_q    <= 1'b0;
         refused_q <= 1'b0;
      end else if (en) begin
         done_q    <= (fin_ok || (wr_last && op_q != OP_PROGRAM && op_q != OP_SUSPEND)
                      || (st_q == ST_RD_ONE && eng_done))
                      || (done_q && !(apb_wr && paddr == REG_STATUS && pwdata[ST_DONE]));
         fail_q    <= fin_bad || (fail_q && !(apb_wr && paddr == REG_STATUS && pwdata[ST_FAIL]));
         refused_q <= (wr_ctrl && !accept)
                      || (refused_q && !(apb_wr && paddr == REG_STATUS && pwdata[ST_REFUSED]));
      end
   end
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         rdata_q     <= 8'h00;
         stat_byte_q <= 8'h00;
      end else if (en) begin
         if (st_q == ST_RD_ONE && eng_done) begin
            rdata_q <= eng_rdata;
         end
         if (eval) begin
            stat_byte_q <= eng_rdata;
         end
      end
   end
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         addr_q  <= 20'h00000;
         wdata_q <= 8'h00;
      end else if (en && apb_wr && st_q == ST_IDLE) begin
         if (paddr == REG_ADDR) begin
            addr_q <= pwdata[19:0];
         end
         if (paddr == REG_WDATA) begin
            wdata_q <= pwdata[7:0];
         end
      end
   end

   assign mapped  = (paddr == REG_CTRL) || (paddr == REG_ADDR) || (paddr == REG_WDATA)
                    || (paddr == REG_STATUS) || (paddr == REG_RDATA);
   assign pready  = 1'b1;
   assign pslverr = psel && penable && !mapped;
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         prdata <= 32'h00000000;
      end else if (en && psel && !penable) begin
         prdata <= 32'h00000000;
         case (paddr)
            REG_CTRL:   prdata[2:0] <= op_q;
            REG_ADDR:   prdata[19:0] <= addr_q;
            REG_WDATA:  prdata[7:0] <= wdata_q;
            REG_STATUS: begin
               prdata[ST_BUSY]    <= (st_q != ST_IDLE);
               prdata[ST_DONE]    <= done_q;
               prdata[ST_FAIL]    <= fail_q;
               prdata[ST_REFUSED] <= refused_q;
               prdata[ST_WINDOW]  <= window_open;
               prdata[ST_SUSP]    <= suspended_q;
               prdata[ST_ERASING] <= erasing_q;
               prdata[ST_BYTE_LO +: 8] <= stat_byte_q;
            end
            REG_RDATA:  prdata[7:0] <= rdata_q;
            default:    prdata <= 32'h00000000;
         endcase
      end
   end
   fesq_cycle u_cycle (
      .clk (clk), .rst_n (rst_n), .en (en), .req (eng_req), .is_write (st_q == ST_WR),
      .addr ((st_q == ST_WR) ? word[27:8] : addr_q), .wdata (word[7:0]), .done (eng_done), .rdata (eng_rdata),
      .flash_ce_n (flash_ce_n), .flash_we_n (flash_we_n), .flash_oe_n (flash_oe_n), .flash_addr (flash_addr),
      .flash_dq_o (flash_dq_o), .flash_dq_oe_n (flash_dq_oe_n), .flash_dq_i (flash_dq_i)
   );
endmodule // fesq_host

// >>> verif/fesq_host_assertions.sv
// checker of flash strobe timing, unlock order and apb error answer
// assumes only the ports of fesq_host; bound at the foot
`timescale 1ns/100ps
module fesq_host_chk
   import fesq_pkg::*;
(
   input wire logic        clk,
   input wire logic        resetn,
   input wire logic        psel,
   input wire logic        penable,
   input wire logic [11:0] paddr,
   input wire logic        pslverr,
   input wire logic        flash_ce_n,
   input wire logic        flash_we_n,
   input wire logic        flash_oe_n,
   input wire logic [19:0] flash_addr,
   input wire logic [7:0]  flash_dq_o,
   input wire logic        flash_dq_oe_n
);
   logic [27:0] last_q;
   default clocking cb @(posedge clk); endclocking
   default disable iff (!resetn);
   always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) last_q <= '0;
      else if ($rose(flash_we_n)) last_q <= {flash_addr, flash_dq_o};
   end
   sequence s_we_pulse;
      !flash_we_n [*5] ##1 flash_we_n;
   endsequence
   sequence s_held;
      ($stable(flash_addr) && $stable(flash_dq_o)) [*5];
   endsequence
   property p_we_width;
      $fell(flash_we_n) |-> s_we_pulse;
   endproperty
   a_we_width: assert property (p_we_width)
      else $error("write strobe width wrong");
   property p_hold;
      $fell(flash_we_n) |-> s_held;
   endproperty
   a_hold: assert property (p_hold)
      else $error("address or data moved in write");
   property p_we_in_ce;
      !flash_we_n |-> !flash_ce_n && !flash_dq_oe_n && $past(!flash_ce_n);
   endproperty
   a_we_in_ce: assert property (p_we_in_ce)
      else $error("write strobe outside select");
   property p_no_contend;
      !flash_oe_n |-> flash_dq_oe_n && flash_we_n && !flash_ce_n;
   endproperty
   a_no_contend: assert property (p_no_contend)
      else $error("read while driving data");
   property p_oe_width;
      $fell(flash_oe_n) |-> ##11 !flash_oe_n ##1 flash_oe_n;
   endproperty
   a_oe_width: assert property (p_oe_width)
      else $error("read strobe width wrong");
   property p_ce_gap;
      $rose(flash_ce_n) |=> flash_ce_n;
   endproperty
   a_ce_gap: assert property (p_ce_gap)
      else $error("select gap too short");
   property p_unlock;
      $fell(flash_we_n) && last_q == 28'h00555aa |-> flash_addr[10:0] == 11'h2aa && flash_dq_o == 8'h55;
   endproperty
   a_unlock: assert property (p_unlock)
      else $error("second unlock write wrong");
   property p_slverr;
      psel && penable && paddr > REG_RDATA |-> pslverr;
   endproperty
   a_slverr: assert property (p_slverr)
      else $error("unmapped access not flagged");
endmodule // fesq_host_chk
bind fesq_host fesq_host_chk u_chk (.*);

// >>> verif/fesq_flash_model.sv
// behavioural byte-wide flash: command decoder, erase timer and status bits
// assumes strobes from fesq_host; delays in ns, shortened for simulation
`timescale 1ns/100ps
module fesq_flash_model #(
   parameter int WIN_NS = 2000,
   parameter int ERS_NS = 20000,
   parameter int PRG_NS = 300
)(
   input  wire logic        flash_ce_n,
   input  wire logic        flash_we_n,
   input  wire logic        flash_oe_n,
   input  wire logic [19:0] flash_addr,
   input  wire logic [7:0]  flash_dq_o,
   input  wire logic        flash_dq_oe_n,
   input  wire logic        fail_mode,
   output logic [7:0]       flash_dq_i
);
   logic [7:0]  mem [logic [19:0]];
   logic [27:0] wlog [$];
   logic [19:0] pa;
   logic [15:0] secs = '0;
   logic [10:0] a;
   logic [7:0]  pd, d, q = '0;
   logic        arm = '0, win = '0, ers = '0, susp = '0, prg = '0, tg = '0, tg2 = '0, wsel = '0;
   int          step = 0;
   realtime     t_win, t_ers, t_prg, t_rem;
   // released bus shows the inverse of the last byte
   assign flash_dq_i = (!flash_ce_n && !flash_oe_n) ? q : ~q;
   // select is judged as the write strobe falls: it rises together with the strobe at the end
   always @(negedge flash_we_n) wsel = !flash_ce_n;
   always @(posedge flash_we_n) if (wsel) begin
      a = flash_addr[10:0];
      d = flash_dq_o;
      wlog.push_back({flash_addr, d});
      if (arm) begin
         arm = 0;
         pa = flash_addr;
         pd = d;
         prg = 1;
         t_prg = $realtime + PRG_NS;
      end else if (win && d == 8'h30) begin
         secs[flash_addr[19:16]] = 1;
         t_win = $realtime + WIN_NS;
      end else if (win) begin
         win = 0;
         susp = d == 8'hb0;
         ers = susp;
         t_rem = ERS_NS;
      end else if (ers && !susp) begin
         susp = d == 8'hb0;
         t_rem = t_ers - $realtime;
      end else if (d == 8'hf0) begin
         {prg, ers, susp, step} = '0;
      end else if (prg) begin
      end else if (susp && d == 8'h30) begin
         susp = 0;
         t_ers = $realtime + t_rem;
      end else if (step == 0 || step == 3) step = (a == 11'h555 && d == 8'haa) ? step + 1 : 0;
      else if (step == 1 || step == 4) step = (a == 11'h2aa && d == 8'h55) ? step + 1 : 0;
      else if (step == 2) begin
         arm = a == 11'h555 && d == 8'ha0;
         step = (a == 11'h555 && d == 8'h80 && !susp) ? 3 : 0;
      end else begin
         step = 0;
         ers = d == 8'h30;
         win = ers;
         secs = 16'h0001 << flash_addr[19:16];
         t_win = $realtime + WIN_NS;
      end
   end
   always begin
      #10;
      if (win && $realtime >= t_win) begin
         win = 0;
         t_ers = $realtime + ERS_NS;
      end
      if (ers && !win && !susp && $realtime >= t_ers) begin
         foreach (mem[k]) if (secs[k[19:16]]) mem[k] = 8'hff;
         ers = 0;
      end
      if (prg && !fail_mode && $realtime >= t_prg) begin
         prg = 0;
         mem[pa] = pd;
      end
   end
   always @(negedge flash_oe_n) if (!flash_ce_n) begin
      if (prg) q = {~pd[7], tg, fail_mode, 5'h04};
      else if (ers && !susp) q = {1'b0, tg, 2'h0, !win, tg2 & secs[flash_addr[19:16]], 2'h0};
      else if (susp && secs[flash_addr[19:16]]) q = {5'h18, tg2, 2'h0};
      else q = mem.exists(flash_addr) ? mem[flash_addr] : 8'hff;
      tg = ~tg;
      tg2 = ~tg2;
   end
endmodule // fesq_flash_model

// >>> verif/fesq_host_test.sv
// self-checking bench: apb orders to fesq_host against a flash model
// assumes shortened window and suspend counts; one 100 MHz clock
`timescale 1ns/100ps
module fesq_host_test
   import fesq_pkg::*;
;
   logic        clk = 0, resetn = 0, psel = 0, penable = 0, pwrite = 0, fail_mode = 0;
   logic        pready, pslverr, err, flash_ce_n, flash_we_n, flash_oe_n, flash_dq_oe_n;
   logic [11:0] paddr = '0;
   logic [31:0] pwdata = '0, prdata, rd;
   logic [19:0] flash_addr;
   logic [7:0]  flash_dq_o, flash_dq_i;
   int          n_mismatch = 0, checks_done = 0;
   always #5 clk = ~clk;
   fesq_host #(.LOAD_CYC(200), .SUSP_CYC(300)) uut (.*, .en(1'b1));
   fesq_flash_model fm (.*);
   task automatic chk(input string s, input logic [31:0] e, input logic [31:0] g);
      checks_done++;
      if (g !== e) begin
         n_mismatch++;
         $display("wrong value %s expected %h seen %h", s, e, g);
      end
   endtask
   task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
      @(posedge clk);
      psel <= 1;
      penable <= 0;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge clk);
      penable <= 1;
      do @(posedge clk); while (pready !== 1'b1);
      rd = prdata;
      err = pslverr;
      psel <= 0;
      penable <= 0;
   endtask
   task automatic op(input fesq_op_t o, input logic [19:0] a, input logic [7:0] d);
      apb(1, REG_STATUS, 32'he);
      apb(1, REG_ADDR, {12'h0, a});
      apb(1, REG_WDATA, {24'h0, d});
      apb(1, REG_CTRL, {29'h0, o});
      repeat (3000) begin
         apb(0, REG_STATUS, '0);
         if (rd[ST_BUSY] === 1'b0) break;
      end
   endtask
   task automatic rdb(input logic [19:0] a);
      op(OP_READ, a, '0);
      apb(0, REG_RDATA, '0);
   endtask
   task automatic seq(input logic [27:0] e[$]);
      chk("writes", e.size(), fm.wlog.size());
      foreach (e[i]) chk("write", e[i], fm.wlog[i]);
      fm.wlog.delete();
   endtask
   task automatic t_regs;
      apb(0, REG_STATUS, '0);
      chk("status", '0, rd);
      apb(1, REG_ADDR, 32'h00fabcde);
      apb(0, REG_ADDR, '0);
      chk("addr", 32'h000abcde, rd);
      apb(0, 12'h020, '0);
      chk("unmapped", '0, rd);
      chk("slverr", 1'b1, err);
      $display("t_regs end");
   endtask
   task automatic t_prog;
      fm.wlog.delete();
      op(OP_PROGRAM, 20'h12345, 8'h3c);
      chk("prog", 3'h2, rd[2:0]);
      seq({28'h00555aa, 28'h002aa55, 28'h00555a0, 28'h123453c});
      rdb(20'h12345);
      chk("rdata", 8'h3c, rd);
      $display("t_prog end");
   endtask
   task automatic t_erase;
      op(OP_PROGRAM, 20'h30010, 8'h5a);
      fm.wlog.delete();
      op(OP_ERASE, 20'h30000, '0);
      op(OP_ADD, 20'h50000, '0);
      chk("window", 3'h5, rd[6:4]);
      seq({28'h00555aa, 28'h002aa55, 28'h0055580, 28'h00555aa, 28'h002aa55, 28'h3000030, 28'h5000030});
      rdb(20'h30000);
      chk("load poll", '0, rd & 32'h88);
      op(OP_POLL, 20'h30000, '0);
      chk("erase", 3'h2, rd[2:0]);
      rdb(20'h30010);
      chk("erased", 8'hff, rd);
      $display("t_erase end");
   endtask
   task automatic t_susp;
      op(OP_ERASE, 20'h20000, '0);
      repeat (300) @(posedge clk);
      op(OP_ADD, 20'h80000, '0);
      chk("late add", 1'b1, rd[ST_REFUSED]);
      rdb(20'h20000);
      chk("erase poll", 8'h08, rd & 32'h88);
      op(OP_SUSPEND, 20'h20000, '0);
      chk("susp", 2'h3, rd[6:5]);
      rdb(20'h20004);
      chk("susp read", 8'hc0, rd & 32'hfb);
      op(OP_PROGRAM, 20'h40020, 8'h96);
      chk("susp prog", 3'h2, rd[2:0]);
      rdb(20'h40020);
      chk("other sector", 8'h96, rd);
      op(OP_RESUME, '0, '0);
      chk("resume", 2'h2, rd[6:5]);
      op(OP_POLL, 20'h20000, '0);
      chk("poll", 3'h2, rd[2:0]);
      $display("t_susp end");
   endtask
   task automatic t_refuse;
      op(OP_SUSPEND, '0, '0);
      chk("idle susp", 1'b1, rd[ST_REFUSED]);
      op(OP_RESUME, '0, '0);
      chk("idle resume", 1'b1, rd[ST_REFUSED]);
      op(OP_ERASE, 20'h10000, '0);
      op(OP_RESET, '0, '0);
      rdb(20'h12345);
      chk("abort", 8'h3c, rd);
      $display("t_refuse end");
   endtask
   task automatic t_fail;
      fail_mode <= 1'b1;
      op(OP_PROGRAM, 20'h60000, 8'h11);
      chk("fail", 3'h6, rd[2:0]);
      chk("poll byte", 8'ha4, rd[15:8] & 8'ha4);
      chk("reset code", 8'hf0, fm.wlog[$][7:0]);
      fail_mode <= 1'b0;
      op(OP_PROGRAM, 20'h60001, 8'h22);
      chk("after fail", 3'h2, rd[2:0]);
      $display("t_fail end");
   endtask
   task automatic results;
      $display("checks %0d mismatches %0d", checks_done, n_mismatch);
      if (n_mismatch == 0 && checks_done > 0) $display("Finished cleanly");
      else $display("Finished with errors");
      $finish;
   endtask
   initial begin
      repeat (4) @(posedge clk);
      resetn <= 1;
      repeat (3) @(posedge clk);
      t_regs;
      t_prog;
      t_erase;
      t_susp;
      t_refuse;
      t_fail;
      results;
   end
   initial begin
      #300us;
      n_mismatch++;
      results;
   end
endmodule // fesq_host_test
